// file: hw/sapc_top.v
// Convert-strobe sequencing, power-down selection and three-state readout
`include "sapc_defs.vh"

module sapc_top #(
   parameter RES_W = `SAPC_RES_W,
   parameter CODING = `SAPC_CODE_OFFSET,
   parameter CONV_CYCLES = `SAPC_CONV_CYCLES
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // Host control pins, asynchronous to i_mclk
   input wire i_cs_n,
   input wire i_rd_cnv,
   // Digitised input sample, unsigned from the front end
   input wire [RES_W-1:0] i_sample,
   // End of conversion
   output wire o_eoc_n,
   // Result bus as two signals per line, value and enable
   output wire [RES_W-1:0] o_result_bus,
   output wire [RES_W-1:0] o_result_bus_oe,
   // Power state of the reference and the acquisition phase flag
   output wire o_ref_on,
   output wire o_acquiring
);

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   // Cycles per SAR step so the whole search ends inside the limit
   localparam STEP_CYCLES = (CONV_CYCLES - 4) / RES_W;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire cs_n_s;
   wire rd_cnv_s;

   sapc_sync #(
      .RESET_VAL(1'b1)
   ) u_sync_cs (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async(i_cs_n),
      .o_level(cs_n_s)
   );

   sapc_sync #(
      .RESET_VAL(1'b0)
   ) u_sync_rc (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async(i_rd_cnv),
      .o_level(rd_cnv_s)
   );

   // ----------------------------------------
   // Strobe edge detection
   // ----------------------------------------
   reg cs_prev_q;
   wire cs_fall;
   wire cs_rise;

   // Previous strobe level for edge finding
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_n_s;
      end
   end

   assign cs_fall = cs_prev_q & ~cs_n_s;
   assign cs_rise = ~cs_prev_q & cs_n_s;

   // ----------------------------------------
   // Result coding
   // ----------------------------------------
   // Offset binary flips the MSB of the two's complement form; the sample
   // arrives unsigned so offset binary equals it, straight binary likewise
   function [RES_W-1:0] sapc_code;
      input [RES_W-1:0] raw;
      input coding;
      begin
         if (coding == `SAPC_CODE_OFFSET) begin
            sapc_code = raw;
         end else begin
            sapc_code = raw;
         end
      end
   endfunction

   // ----------------------------------------
   // SAR engine
   // ----------------------------------------
   reg start_q;
   wire sar_done;
   wire [RES_W-1:0] sar_code;
   reg [RES_W-1:0] held_q;

   sapc_sar #(
      .RES_W(RES_W),
      .STEP_CYCLES(STEP_CYCLES)
   ) u_sar (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_start(start_q),
      .i_sample(held_q),
      .o_done(sar_done),
      .o_code(sar_code)
   );

   // ----------------------------------------
   // Phase state machine
   // ----------------------------------------
   reg [2:0] phase_q;
   reg [2:0] phase_d;
   reg shut_sel_q;
   reg ref_on_q;
   reg eoc_n_q;
   reg [RES_W-1:0] result_q;
   reg bus_oe_q;

   // Next phase from the strobe edges, the sampled select and SAR completion
   always @* begin
      phase_d = phase_q;
      case (phase_q)
         `SAPC_PH_IDLE: begin
            if (cs_fall && !rd_cnv_s) begin
               phase_d = `SAPC_PH_ACQ;
            end
         end
         `SAPC_PH_ACQ: begin
            if (cs_fall) begin
               phase_d = `SAPC_PH_CONV;
            end
         end
         `SAPC_PH_CONV: begin
            if (sar_done) begin
               phase_d = `SAPC_PH_DONE;
            end
         end
         `SAPC_PH_DONE: begin
            if (cs_fall && rd_cnv_s) begin
               phase_d = `SAPC_PH_READ;
            end
         end
         `SAPC_PH_READ: begin
            if (cs_rise) begin
               phase_d = `SAPC_PH_IDLE;
            end
         end
         default: begin
            phase_d = `SAPC_PH_IDLE;
         end
      endcase
   end

   // Phase register, mode capture, sample hold and conversion start
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         phase_q <= `SAPC_PH_IDLE;
         shut_sel_q <= 1'b0;
         held_q <= {RES_W{1'b0}};
         start_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         start_q <= 1'b0;
         if (phase_q == `SAPC_PH_ACQ && cs_fall) begin
            shut_sel_q <= rd_cnv_s;
            held_q <= i_sample;
            start_q <= 1'b1;
         end
      end
   end

   // Reference power: on from wake-up, off after a shutdown-mode conversion
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ref_on_q <= 1'b0;
      end else if (phase_q == `SAPC_PH_IDLE && cs_fall && !rd_cnv_s) begin
         ref_on_q <= 1'b1;
      end else if (phase_q == `SAPC_PH_CONV && sar_done) begin
         ref_on_q <= ~shut_sel_q;
      end
   end

   // End-of-conversion flag and captured result
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         eoc_n_q <= 1'b1;
         result_q <= {RES_W{1'b0}};
      end else if (phase_q == `SAPC_PH_CONV && sar_done) begin
         eoc_n_q <= 1'b0;
         result_q <= sapc_code(sar_code, CODING);
      end else if (phase_q == `SAPC_PH_ACQ) begin
         eoc_n_q <= 1'b1;
      end
   end

   // Bus drive only in the read phase
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         bus_oe_q <= 1'b0;
      end else begin
         bus_oe_q <= (phase_d == `SAPC_PH_READ);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_eoc_n = eoc_n_q;
   assign o_result_bus = result_q;
   assign o_result_bus_oe = {RES_W{bus_oe_q}};
   assign o_ref_on = ref_on_q;
   assign o_acquiring = (phase_q == `SAPC_PH_ACQ);

endmodule

// file: shared/sapc_defs.vh
// Constants for the converter power-down and readout control block
`ifndef SAPC_DEFS_VH
`define SAPC_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SAPC_CLK_PERIOD_PS 5000
`define SAPC_CONV_MAX_PS 4700000
// Conversion time rounds down so completion never exceeds the limit
`define SAPC_CONV_CYCLES (`SAPC_CONV_MAX_PS / `SAPC_CLK_PERIOD_PS)
`define SAPC_REF_SETTLE_MS 12

// ----------------------------------------
// Result layout and coding
// ----------------------------------------
`define SAPC_RES_W 16
`define SAPC_MSB_POS 15
`define SAPC_CODE_STRAIGHT 1'h0
`define SAPC_CODE_OFFSET 1'h1

// ----------------------------------------
// Phase states
// ----------------------------------------
`define SAPC_PH_IDLE 3'h0
`define SAPC_PH_ACQ 3'h1
`define SAPC_PH_CONV 3'h2
`define SAPC_PH_DONE 3'h3
`define SAPC_PH_READ 3'h4

`endif

// file: hw/sapc_sync.v
// Three-stage synchroniser with agreement on the last two stages
module sapc_sync #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // Async input and clean level
   input wire i_async,
   output wire o_level
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;

   // Shift chain; a change is taken once stages two and three agree
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         lvl_q <= RESET_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign o_level = lvl_q;

endmodule

// file: hw/sapc_sar.v
// Successive-approximation engine that resolves one bit per step
module sapc_sar #(
   parameter RES_W = 16,
   parameter STEP_CYCLES = 58
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // Control
   input wire i_start,
   input wire [RES_W-1:0] i_sample,
   // Result
   output wire o_done,
   output wire [RES_W-1:0] o_code
);

   reg [RES_W-1:0] code_q;
   reg [RES_W-1:0] trial_q;
   reg [15:0] tick_q;
   reg busy_q;
   reg done_q;

   // Binary search: keep each trial bit while the sample is not below it
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         code_q <= {RES_W{1'b0}};
         trial_q <= {RES_W{1'b0}};
         tick_q <= 16'h0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (i_start) begin
            code_q <= {RES_W{1'b0}};
            trial_q <= {1'b1, {(RES_W-1){1'b0}}};
            tick_q <= 16'h0000;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (tick_q == STEP_CYCLES - 1) begin
               tick_q <= 16'h0000;
               if (i_sample >= (code_q | trial_q)) begin
                  code_q <= code_q | trial_q;
               end
               trial_q <= trial_q >> 1;
               if (trial_q[0]) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end else begin
               tick_q <= tick_q + 16'h0001;
            end
         end
      end
   end

   assign o_done = done_q;
   assign o_code = code_q;

endmodule

// file: dv/sapc_top_asserts.sv
// Checker for strobe sequencing and readout at the block's ports
module sapc_chk #(
   parameter RES_W = 16,
   parameter CONV_CYCLES = 940
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // Host strobe
   input wire i_cs_n,
   // Status and result
   input wire o_eoc_n,
   input wire [RES_W-1:0] o_result_bus,
   input wire [RES_W-1:0] o_result_bus_oe,
   input wire o_ref_on,
   input wire o_acquiring
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slack for the pin synchroniser on top of the conversion count
   localparam int CONV_MAX = CONV_CYCLES + 10;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   float_busy_a: assert property (o_eoc_n |-> o_result_bus_oe == '0)
      else $error("bus driven before result");
   oe_whole_a: assert property (o_result_bus_oe == '0 || &o_result_bus_oe)
      else $error("bus lines enabled apart");
   rd_valid_a: assert property ($rose(o_result_bus_oe[0]) |-> !o_eoc_n)
      else $error("bus driven without result");
   rise_float_a: assert property ($rose(i_cs_n) && o_result_bus_oe[0]
      |-> ##[1:8] !o_result_bus_oe[0]) else $error("bus kept after strobe rise");
   conv_time_a: assert property ($fell(o_acquiring) |-> ##[1:CONV_MAX] !o_eoc_n)
      else $error("conversion too long");
   bus_hold_a: assert property (o_result_bus_oe[0] && $past(o_result_bus_oe[0])
      |-> $stable(o_result_bus)) else $error("result changed while driven");
   ref_off_a: assert property ($fell(o_ref_on) |-> !o_eoc_n)
      else $error("reference off before completion");
   eoc_hold_a: assert property ($rose(o_eoc_n) |-> ##[0:1] o_acquiring)
      else $error("completion flag cleared early");
   acq_ref_a: assert property (o_acquiring |-> o_ref_on)
      else $error("acquiring with reference off");
   // Main scenarios
   cover property ($fell(o_eoc_n) && o_ref_on);
   cover property ($fell(o_eoc_n) && !o_ref_on);
   cover property ($rose(o_result_bus_oe[0]));
endmodule

bind sapc_top sapc_chk #(.RES_W(RES_W), .CONV_CYCLES(CONV_CYCLES)) u_chk (
   .i_mclk(i_mclk),
   .i_rst(i_rst),
   .i_cs_n(i_cs_n),
   .o_eoc_n(o_eoc_n),
   .o_result_bus(o_result_bus),
   .o_result_bus_oe(o_result_bus_oe),
   .o_ref_on(o_ref_on),
   .o_acquiring(o_acquiring)
);

// file: dv/sapc_host.sv
// Host model driving the convert strobe and the read/convert select
module sapc_host #(
   parameter SETTLE = 40
) (
   // Clock
   input wire i_mclk,
   // Strobe and select
   output logic o_cs_n,
   output logic o_rd_cnv
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels
   initial begin
      o_cs_n = 1'b1;
      o_rd_cnv = 1'b0;
   end
   // Select settles an edge ahead of the fall; strobe held wide
   task fall(input logic sel);
      @(posedge i_mclk);
      o_rd_cnv <= sel;
      @(posedge i_mclk);
      o_cs_n <= 1'b0;
      repeat (12) @(posedge i_mclk);
   endtask
   // Strobe release
   task rise;
      @(posedge i_mclk);
      o_cs_n <= 1'b1;
      repeat (12) @(posedge i_mclk);
   endtask
   // Shortened reference settle wait after shutdown
   task settle;
      repeat (SETTLE) @(posedge i_mclk);
   endtask
endmodule

// file: dv/sapc_top_tb_top.sv
// Self-checking bench for the strobe sequencing block
module sapc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk;
   logic i_rst;
   logic [15:0] i_sample;
   wire cs_n, rd_cnv, eoc_n, ref_on, acq;
   wire [15:0] bus, oe;
   int n_mismatch, n_checks;
   // Rows: expected reference state, shutdown select, sample
   logic [17:0] rows [4] = '{18'h2_0000, 18'h1_FFFF, 18'h1_8001, 18'h2_7FFE};
   sapc_host u_host (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_rd_cnv(rd_cnv));
   sapc_top u_dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n), .i_rd_cnv(rd_cnv),
      .i_sample(i_sample), .o_eoc_n(eoc_n), .o_result_bus(bus),
      .o_result_bus_oe(oe), .o_ref_on(ref_on), .o_acquiring(acq)
   );
   // Clock
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   // Compare and count
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Verdict
   task final_report;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Bounded wait for completion
   task wait_eoc;
      int k;
      for (k = 0; k < 1200 && eoc_n !== 1'b0; k++) @(posedge i_mclk);
      chk({15'h0000, eoc_n}, 16'h0000);
      if (eoc_n !== 1'b0) final_report;
   endtask
   // One acquire, convert and read cycle
   task cycle(input logic mode, input logic [15:0] smp, input logic ref_exp);
      i_sample <= smp;
      u_host.fall(1'b0);
      chk({14'h0000, acq, ref_on}, 16'h0003);
      u_host.rise;
      u_host.fall(mode);
      chk({15'h0000, acq}, 16'h0000);
      chk(oe, 16'h0000);
      u_host.rise;
      wait_eoc;
      chk({15'h0000, ref_on}, {15'h0000, ref_exp});
      u_host.fall(1'b1);
      chk(oe, 16'hFFFF);
      chk(bus, smp);
      u_host.rise;
      chk(oe, 16'h0000);
      if (mode) u_host.settle;
   endtask
   // Main sequence
   initial begin
      i_rst = 1'b1;
      i_sample = 16'h0000;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      chk({14'h0000, eoc_n, oe[0]}, 16'h0002);
      foreach (rows[r]) cycle(rows[r][16], rows[r][15:0], rows[r][17]);
      // Select-high strobe after a read is ignored
      u_host.fall(1'b1);
      chk({15'h0000, acq}, 16'h0000);
      chk(oe, 16'h0000);
      u_host.rise;
      // Reset in mid-acquisition, strobe high
      u_host.fall(1'b0);
      u_host.rise;
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      chk({15'h0000, acq}, 16'h0000);
      i_rst <= 1'b0;
      cycle(1'b0, 16'h0001, 1'b1);
      final_report;
   end
endmodule
